// ==== hw/scp_pkg.sv ====
package scp_pkg;
    // byte codes seen by the parser
    localparam logic [7:0] CH_NL = 8'h0A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_COLON = 8'h3A;
    localparam logic [7:0] CH_QUERY = 8'h3F;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_LBRACK = 8'h5B;
    localparam logic [7:0] CH_RBRACK = 8'h5D;
    localparam logic [7:0] CASE_BIT = 8'h20;
    // widths
    localparam int COND_W = 16;
    localparam int STB_W = 8;
    localparam int LVL_W = 4;
    // operation condition bit positions
    localparam int OP_SETTLING = 1;
    localparam int OP_WTG = 5;
    localparam int OP_ARMED = 6;
    localparam int OP_CV = 8;
    localparam int OP_TRAN_DONE = 9;
    localparam int OP_CC = 10;
    localparam int OP_SAMPLE_DONE = 11;
    localparam int OP_LIST_DONE = 12;
    localparam int OP_LIST_RUN = 14;
    // questionable condition bit positions
    localparam int QU_VMODE = 0;
    localparam int QU_CMODE = 1;
    localparam int QU_THERMAL = 3;
    localparam int QU_SLAVE = 6;
    localparam int QU_VPROT = 12;
    localparam int QU_CPROT = 13;
    localparam int QU_SINK = 14;
    // readable and event masks
    localparam logic [15:0] OP_COND_MASK = 16'h4D62;
    localparam logic [15:0] OP_EVT_MASK = 16'h5F62;
    localparam logic [15:0] QU_MASK = 16'h704B;
    // status byte bit positions
    localparam int SB_ERR = 2;
    localparam int SB_QUES = 3;
    localparam int SB_MAV = 4;
    localparam int SB_ESB = 5;
    localparam int SB_RQS = 6;
    localparam int SB_OPER = 7;
    // reset values
    localparam logic [15:0] COND_RST = 16'h0000;
    localparam logic [7:0] STB_RST = 8'h00;
    localparam logic [3:0] LVL_RST = 4'h0;
    // parser states
    typedef enum logic [2:0] {
        SCP_IDLE = 3'b000,
        SCP_KEYWORD = 3'b001,
        SCP_OPTION = 3'b010,
        SCP_DATA = 3'b011,
        SCP_SKIP = 3'b100
    } scp_state_t;
endpackage : scp_pkg

// ==== hw/scp_fifo.sv ====
`timescale 1ns/1ps
module scp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [WIDTH-1:0] in_data, // write word
    input wire logic in_valid, // write offered
    output logic in_ready, // room available
    output logic [WIDTH-1:0] out_data, // head word
    output logic out_valid, // word present
    input wire logic out_ready // reader takes head
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
    logic full, empty, push, pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
        $error("fifo depth must be a power of two");
    end

    // pointers carry one extra bit so full and empty differ
    always_comb begin
        full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
        empty = (wr_reg == rd_reg);
        push = in_valid && !full;
        pop = out_ready && !empty;
        wr_next = wr_reg + (AW+1)'(push);
        rd_next = rd_reg + (AW+1)'(pop);
        in_ready = !full;
        out_valid = !empty;
        out_data = mem[rd_reg[AW-1:0]];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // storage has no reset; only pointers matter
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule : scp_fifo

// ==== hw/scp_parser_status.sv ====
`timescale 1ns/1ps
module scp_parser_status
    import scp_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic core_clk, // 40 MHz system clock
    input wire logic rst, // async reset, high
    input wire logic [7:0] rx_data, // incoming message byte
    input wire logic rx_valid, // byte offered
    output logic rx_ready, // fifo has room
    output logic [7:0] tok_byte, // parameter or keyword byte, keyword bytes upper-cased
    output logic tok_kw, // tok_byte belongs to a keyword
    output logic tok_param, // tok_byte belongs to the parameter
    output logic tok_valid, // one-cycle token strobe
    output logic [scp_pkg::LVL_W-1:0] tok_level, // tree level of the keyword
    output logic kw_end, // pulse: keyword finished
    output logic unit_end, // pulse: message unit finished
    output logic unit_query, // unit is a query, with unit_end
    output logic msg_end, // pulse: message terminator seen
    input wire logic kw_bad, // keyword decoder rejected the form
    input wire logic err_queue_nonempty, // error queue holds entries
    input wire logic out_buf_avail, // response data waiting
    input wire logic esb_summary, // standard event summary
    input wire logic [15:0] op_cond_in, // live operation conditions
    input wire logic [15:0] qu_cond_in, // live questionable conditions
    input wire logic trig_ext_src, // trigger source is external
    input wire logic trig_in_pin, // trigger pin, async
    input wire logic ext_ref_en, // external reference enabled
    input wire logic [15:0] op_enable, // operation event enable
    input wire logic [15:0] questionable_enable_reg, // questionable event enable
    input wire logic [7:0] sre_in, // service request enable
    input wire logic op_event_rd, // read strobe, operation event
    input wire logic qu_event_rd, // read strobe, questionable event
    output logic [15:0] operation_condition, // readable operation condition
    output logic [15:0] questionable_condition, // readable questionable condition
    output logic [15:0] op_event, // operation event register
    output logic [15:0] qu_event, // questionable event register
    output logic [7:0] status_byte, // status byte
    output logic srq, // service request to host
    output logic voltage_limit_trip_display, // voltage protect indicator
    output logic current_limit_trip_display, // current protect indicator
    output logic waiting_for_trigger_flag // trigger wait flag
);
    if (FIFO_DEPTH < 2) begin : g_depth_chk
        $error("fifo depth too small");
    end

    // byte buffer between host and parser
    logic [7:0] fb_data;
    logic fb_valid;
    scp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_data(rx_data),
        .in_valid(rx_valid),
        .in_ready(rx_ready),
        .out_data(fb_data),
        .out_valid(fb_valid),
        .out_ready(1'b1)
    );

    function automatic logic [7:0] upcase(input logic [7:0] c);
        if (c >= 8'h61 && c <= 8'h7A) begin
            return c & ~CASE_BIT;
        end
        return c;
    endfunction : upcase

    // ---------------- parser ----------------
    scp_state_t st_reg, st_next;
    logic [LVL_W-1:0] lvl_reg, lvl_next, base_reg, base_next;
    logic query_reg, query_next, first_reg, first_next;
    logic [7:0] tb_reg, tb_next;
    logic tkw_reg, tkw_next, tpar_reg, tpar_next, tv_reg, tv_next;
    logic [LVL_W-1:0] tl_reg, tl_next;
    logic ke_reg, ke_next, ue_reg, ue_next, uq_reg, uq_next, me_reg, me_next;

    // parser walks bytes; keyword spelling is checked by the decoder via kw_bad
    always_comb begin
        logic [7:0] c;
        c = upcase(fb_data);
        st_next = st_reg;
        lvl_next = lvl_reg;
        base_next = base_reg;
        query_next = query_reg;
        first_next = first_reg;
        tb_next = c;
        tkw_next = 1'b0;
        tpar_next = 1'b0;
        tv_next = 1'b0;
        tl_next = lvl_reg;
        ke_next = 1'b0;
        ue_next = 1'b0;
        uq_next = query_reg;
        me_next = 1'b0;
        if (fb_valid) begin
            if (c == CH_NL) begin
                // terminator closes everything and homes the tree
                me_next = 1'b1;
                ue_next = (st_reg != SCP_IDLE) || !first_reg;
                ke_next = (st_reg == SCP_KEYWORD);
                uq_next = query_reg;
                lvl_next = LVL_RST;
                tl_next = LVL_RST;
                base_next = LVL_RST;
                query_next = 1'b0;
                first_next = 1'b1;
                st_next = SCP_IDLE;
            end else begin
                unique case (st_reg)
                    SCP_IDLE: begin
                        if (c == CH_COLON) begin
                            lvl_next = LVL_RST;
                            base_next = LVL_RST;
                        end else if (c == CH_LBRACK) begin
                            st_next = SCP_OPTION;
                        end else if (c != CH_SPACE) begin
                            // source keyword omitted lands at base_reg, which is root at message start
                            if (c != CH_STAR) begin
                                lvl_next = base_reg;
                            end
                            tkw_next = 1'b1;
                            tv_next = 1'b1;
                            tl_next = (c == CH_STAR) ? LVL_RST : base_reg;
                            st_next = SCP_KEYWORD;
                            first_next = 1'b0;
                        end
                    end
                    SCP_KEYWORD: begin
                        if (c == CH_COLON) begin
                            ke_next = 1'b1;
                            base_next = lvl_reg + 1'b1;
                            lvl_next = lvl_reg + 1'b1;
                        end else if (c == CH_LBRACK) begin
                            ke_next = 1'b1;
                            st_next = SCP_OPTION;
                        end else if (c == CH_QUERY) begin
                            query_next = 1'b1;
                        end else if (c == CH_SPACE) begin
                            ke_next = 1'b1;
                            st_next = SCP_DATA;
                        end else if (c == CH_SEMI) begin
                            ke_next = 1'b1;
                            ue_next = 1'b1;
                            uq_next = query_reg;
                            query_next = 1'b0;
                            st_next = SCP_IDLE;
                        end else begin
                            tkw_next = 1'b1;
                            tv_next = 1'b1;
                            tl_next = lvl_reg;
                        end
                    end
                    SCP_OPTION: begin
                        // bracketed text is skipped; after ']' the parser returns to SCP_IDLE
                        if (c == CH_RBRACK) begin
                            st_next = SCP_IDLE;
                        end
                    end
                    SCP_DATA: begin
                        if (c == CH_SEMI) begin
                            ue_next = 1'b1;
                            uq_next = query_reg;
                            query_next = 1'b0;
                            st_next = SCP_IDLE;
                        end else begin
                            tpar_next = 1'b1;
                            tv_next = 1'b1;
                            tb_next = fb_data;
                        end
                    end
                    SCP_SKIP: begin
                        if (c == CH_SEMI) begin
                            st_next = SCP_IDLE;
                        end
                    end
                    default: st_next = SCP_IDLE;
                endcase
                // a rejected keyword spelling drops the rest of the unit
                if (kw_bad && st_reg == SCP_KEYWORD && c != CH_SEMI) begin
                    st_next = SCP_SKIP;
                    tv_next = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= SCP_IDLE;
            lvl_reg <= LVL_RST;
            base_reg <= LVL_RST;
            query_reg <= 1'b0;
            first_reg <= 1'b1;
            tb_reg <= 8'h00;
            tkw_reg <= 1'b0;
            tpar_reg <= 1'b0;
            tv_reg <= 1'b0;
            tl_reg <= LVL_RST;
            ke_reg <= 1'b0;
            ue_reg <= 1'b0;
            uq_reg <= 1'b0;
            me_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            lvl_reg <= lvl_next;
            base_reg <= base_next;
            query_reg <= query_next;
            first_reg <= first_next;
            tb_reg <= tb_next;
            tkw_reg <= tkw_next;
            tpar_reg <= tpar_next;
            tv_reg <= tv_next;
            tl_reg <= tl_next;
            ke_reg <= ke_next;
            ue_reg <= ue_next;
            uq_reg <= uq_next;
            me_reg <= me_next;
        end
    end

    // ---------------- trigger pin sync ----------------
    logic [2:0] trg_sync_reg, trg_sync_next;
    logic trg_reg, trg_next, wtg_hold_reg, wtg_hold_next;

    // three stages; a change counts once stages two and three agree
    always_comb begin
        trg_sync_next = {trg_sync_reg[1:0], trig_in_pin};
        trg_next = (trg_sync_reg[1] == trg_sync_reg[2]) ? trg_sync_reg[2] : trg_reg;
        wtg_hold_next = trig_ext_src && op_cond_in[OP_WTG] && !trg_reg;
        if (trg_reg && !(op_cond_in[OP_WTG] && trig_ext_src)) begin
            wtg_hold_next = 1'b0;
        end
        if (wtg_hold_reg && trig_ext_src && !trg_reg) begin
            wtg_hold_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trg_sync_reg <= 3'b111;
            trg_reg <= 1'b1;
            wtg_hold_reg <= 1'b0;
        end else begin
            trg_sync_reg <= trg_sync_next;
            trg_reg <= trg_next;
            wtg_hold_reg <= wtg_hold_next;
        end
    end

    // ---------------- status structure ----------------
    logic [15:0] opc_reg, opc_next, quc_reg, quc_next;
    logic [15:0] ope_reg, ope_next, que_reg, que_next;
    logic [15:0] op_live, qu_live, ocr_reg, ocr_next;
    logic [7:0] sb_reg, sb_next;
    logic srq_reg, srq_next, vp_reg, vp_next, cp_reg, cp_next, wtg_reg, wtg_next;

    // condition reads are pure views; nothing here reacts to them
    always_comb begin
        logic [7:0] sb_raw;
        sb_raw = STB_RST;
        op_live = op_cond_in & OP_EVT_MASK;
        op_live[OP_WTG] = op_cond_in[OP_WTG] || wtg_hold_reg;
        qu_live = qu_cond_in & QU_MASK;
        if (ext_ref_en && (qu_cond_in[QU_VPROT] || qu_cond_in[QU_CPROT])) begin
            qu_live[QU_VPROT] = 1'b1;
            qu_live[QU_CPROT] = 1'b1;
        end
        opc_next = op_live;
        ocr_next = op_live & OP_COND_MASK;
        quc_next = qu_live;
        // set beats the read-clear in the same cycle
        ope_next = (op_event_rd ? COND_RST : ope_reg) | (op_live & ~opc_reg);
        que_next = (qu_event_rd ? COND_RST : que_reg) | (qu_live & ~quc_reg);
        sb_raw[SB_ERR] = err_queue_nonempty;
        sb_raw[SB_QUES] = |(que_reg & questionable_enable_reg) || err_queue_nonempty;
        sb_raw[SB_MAV] = out_buf_avail;
        sb_raw[SB_ESB] = esb_summary;
        sb_raw[SB_OPER] = |(ope_reg & op_enable);
        sb_raw[SB_RQS] = |(sb_raw & sre_in & ~(8'h01 << SB_RQS));
        sb_next = sb_raw;
        srq_next = sb_raw[SB_RQS];
        vp_next = qu_live[QU_VPROT];
        cp_next = qu_live[QU_CPROT];
        wtg_next = op_live[OP_WTG];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            opc_reg <= COND_RST;
            ocr_reg <= COND_RST;
            quc_reg <= COND_RST;
            ope_reg <= COND_RST;
            que_reg <= COND_RST;
            sb_reg <= STB_RST;
            srq_reg <= 1'b0;
            vp_reg <= 1'b0;
            cp_reg <= 1'b0;
            wtg_reg <= 1'b0;
        end else begin
            opc_reg <= opc_next;
            ocr_reg <= ocr_next;
            quc_reg <= quc_next;
            ope_reg <= ope_next;
            que_reg <= que_next;
            sb_reg <= sb_next;
            srq_reg <= srq_next;
            vp_reg <= vp_next;
            cp_reg <= cp_next;
            wtg_reg <= wtg_next;
        end
    end

    // outputs straight from flip-flops
    assign tok_byte = tb_reg;
    assign tok_kw = tkw_reg;
    assign tok_param = tpar_reg;
    assign tok_valid = tv_reg;
    assign tok_level = tl_reg;
    assign kw_end = ke_reg;
    assign unit_end = ue_reg;
    assign unit_query = uq_reg;
    assign msg_end = me_reg;
    assign operation_condition = ocr_reg;
    assign questionable_condition = quc_reg;
    assign op_event = ope_reg;
    assign qu_event = que_reg;
    assign status_byte = sb_reg;
    assign srq = srq_reg;
    assign voltage_limit_trip_display = vp_reg;
    assign current_limit_trip_display = cp_reg;
    assign waiting_for_trigger_flag = wtg_reg;
endmodule : scp_parser_status

// ==== sim/scp_host_model.sv ====
`timescale 1ns/1ps
module scp_host_model (
    input wire logic core_clk, // system clock
    output logic [7:0] rx_data, // byte to the device
    output logic rx_valid, // byte offered
    input wire logic rx_ready, // device can take a byte
    output logic hung // a byte was never taken
);
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'h0;
        hung = 1'h0;
    end
    // one byte per accepted edge; gap makes a slow host; messages end in line feed
    task automatic send(input string s, input int gap);
        logic r;
        int n;
        for (int i = 0; i < s.len(); i++) begin
            rx_data <= s[i];
            rx_valid <= 1'h1;
            n = 0;
            do begin
                @(negedge core_clk);
                r = rx_ready;
                @(posedge core_clk);
                n++;
            end while (!r && n < 64);
            if (!r) hung = 1'h1;
            // released data shows the inverse, so a stale byte is never read as fresh
            if (gap != 0) begin
                rx_valid <= 1'h0;
                rx_data <= ~s[i];
                @(posedge core_clk);
            end
        end
        rx_valid <= 1'h0;
        rx_data <= ~s[s.len()-1];
    endtask : send
endmodule : scp_host_model

// ==== sim/scp_parser_status_chk.sv ====
`timescale 1ns/1ps
module scp_parser_status_chk
    import scp_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // reset
    input wire logic [15:0] qu_cond_in, // live conditions
    input wire logic ext_ref_en, // external reference
    input wire logic [15:0] questionable_enable_reg, // enable
    input wire logic [7:0] sre_in, // request enable
    input wire logic qu_event_rd, // read-clear
    input wire logic err_queue_nonempty, // errors queued
    input wire logic out_buf_avail, // response waiting
    input wire logic [15:0] operation_condition, // op condition
    input wire logic [15:0] questionable_condition, // qu condition
    input wire logic [15:0] qu_event, // qu event
    input wire logic [7:0] status_byte, // status byte
    input wire logic srq, // service request
    input wire logic msg_end, // terminator pulse
    input wire logic unit_end, // unit pulse
    input wire logic [3:0] tok_level // tree level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic up;
    logic [15:0] q_d;
    wire [15:0] qrise = questionable_condition & ~q_d;
    // up masks the first edge after reset, where past inputs are stale
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            up <= 1'h0;
            q_d <= 16'h0000;
        end else begin
            up <= 1'h1;
            q_d <= questionable_condition;
        end
    end
    sequence s_qrise;
        up && (qrise != 16'h0000);
    endsequence
    a_op_unused: assert property ((operation_condition & ~OP_COND_MASK) == 16'h0000)
        else $error("operation condition shows an unused bit");
    a_qu_unused: assert property ((questionable_condition & ~QU_MASK) == 16'h0000)
        else $error("questionable condition shows an unused bit");
    a_qu_follow: assert property (up && !$past(ext_ref_en) |->
        questionable_condition == ($past(qu_cond_in) & QU_MASK)) else $error("condition not live");
    a_prot_pair: assert property (up && $past(ext_ref_en) && ($past(qu_cond_in) & 16'h3000) != 16'h0000
        |-> questionable_condition[13:12] == 2'h3) else $error("protect bits not paired");
    a_event_set: assert property (s_qrise |-> (qu_event & qrise) == qrise)
        else $error("rising condition missed by event");
    a_event_hold: assert property (up && !qu_event_rd |=> (qu_event & $past(qu_event)) == $past(qu_event))
        else $error("event bit lost without read");
    a_event_clear: assert property (up && qu_event_rd |=>
        qu_event == (questionable_condition & ~$past(questionable_condition)))
        else $error("event not cleared by read");
    a_ques_sum: assert property (up && (qu_event & questionable_enable_reg) != 16'h0000 |=> status_byte[3])
        else $error("questionable summary missing");
    a_err_sum: assert property (err_queue_nonempty |=> status_byte[3])
        else $error("error summary missing");
    a_mav_bit: assert property (up |=> status_byte[4] == $past(out_buf_avail))
        else $error("message available bit wrong");
    a_rqs_mask: assert property (up |-> status_byte[6] == |(status_byte & $past(sre_in) & 8'hBF))
        else $error("request bit without enabled cause");
    a_srq_rqs: assert property (srq == status_byte[6])
        else $error("srq differs from request bit");
    a_term_root: assert property (msg_end |-> unit_end && tok_level == 4'h0)
        else $error("terminator did not close unit at root");
endmodule : scp_parser_status_chk

// ==== sim/scp_parser_status_tb.sv ====
`timescale 1ns/1ps
module scp_parser_status_tb;
    import scp_pkg::*;
    typedef struct {string msg; string lv; string kw; string pr; int nq;} scp_row_t;
    logic core_clk, rst, rx_valid, rx_ready, tok_kw, tok_param, tok_valid, kw_end, unit_end, hung;
    logic unit_query, msg_end, kw_bad, err_queue_nonempty, out_buf_avail, esb_summary, srq;
    logic trig_ext_src, trig_in_pin, ext_ref_en, op_event_rd, qu_event_rd, first;
    logic voltage_limit_trip_display, current_limit_trip_display, waiting_for_trigger_flag;
    logic [7:0] rx_data, tok_byte, sre_in, status_byte;
    logic [3:0] tok_level;
    logic [15:0] op_cond_in, qu_cond_in, op_enable, questionable_enable_reg, operation_condition;
    logic [15:0] questionable_condition, op_event, qu_event;
    int miscompares, n_checks, nq;
    string lv_s, kw_s, pr_s;
    // legal spellings only: message, keyword levels, upper-cased keywords, data, queries
    scp_row_t rows[6] = '{'{"VOLT:LEV:TRIG 14\n", "012", "VOLTLEVTRIG", "14", 0},
        '{":CURR:LEV:IMM 4\n", "012", "CURRLEVIMM", "4", 0}, '{"STAT:OPER?;PRES\n", "011", "STATOPERPRES", "", 1},
        '{"VOLT:LEV 6;:CURR:LEV 15\n", "0101", "VOLTLEVCURRLEV", "615", 0},
        '{"meas:volt?;:curr?\n", "010", "MEASVOLTCURR", "", 2}, '{"[sour:]volt 3\n", "0", "VOLT", "3", 0}};
    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    scp_parser_status #(.FIFO_DEPTH(16)) uut (.core_clk, .rst, .rx_data, .rx_valid, .rx_ready, .tok_byte,
        .tok_kw, .tok_param, .tok_valid, .tok_level, .kw_end, .unit_end, .unit_query, .msg_end, .kw_bad,
        .err_queue_nonempty, .out_buf_avail, .esb_summary, .op_cond_in, .qu_cond_in, .trig_ext_src,
        .trig_in_pin, .ext_ref_en, .op_enable, .questionable_enable_reg, .sre_in, .op_event_rd, .qu_event_rd,
        .operation_condition, .questionable_condition, .op_event, .qu_event, .status_byte, .srq,
        .voltage_limit_trip_display, .current_limit_trip_display, .waiting_for_trigger_flag);
    scp_host_model host (.core_clk, .rx_data, .rx_valid, .rx_ready, .hung);
    task automatic ck(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : ck
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : settle
    task automatic test_done;
        if (miscompares == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // collect tokens at the falling edge, where registered outputs are settled
    always @(negedge core_clk) begin
        if (tok_valid && tok_kw) begin
            if (first) lv_s = $sformatf("%s%0d", lv_s, tok_level);
            kw_s = $sformatf("%s%c", kw_s, tok_byte);
            first = 1'h0;
        end
        if (tok_valid && tok_param) pr_s = $sformatf("%s%c", pr_s, tok_byte);
        if (kw_end || unit_end) first = 1'h1;
        if (unit_end && unit_query) nq++;
    end
    initial begin
        {rst, first} = 2'h3;
        {kw_bad, err_queue_nonempty, out_buf_avail, esb_summary, trig_ext_src, trig_in_pin} = 6'h00;
        {ext_ref_en, op_event_rd, qu_event_rd, sre_in, op_enable} = 27'h0;
        {op_cond_in, qu_cond_in, questionable_enable_reg} = 48'h0;
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        settle(0);
        ck("reset", {rx_ready, srq, status_byte, qu_event[5:0]}, 16'h8000);
        foreach (rows[i]) begin
            lv_s = "";
            kw_s = "";
            pr_s = "";
            nq = 0;
            @(posedge core_clk);
            host.send(rows[i].msg, i % 2);
            settle(6);
            ck("levels", 16'(lv_s == rows[i].lv), 16'h0001);
            ck("keywords", 16'(kw_s == rows[i].kw), 16'h0001);
            ck("data", 16'(pr_s == rows[i].pr), 16'h0001);
            ck("queries", 16'(nq), 16'(rows[i].nq));
        end
        // rejected spelling drops the rest of each unit
        kw_s = "";
        pr_s = "";
        @(posedge core_clk);
        kw_bad <= 1'h1;
        host.send("VOLT:LEV 5;CURR 2\n", 0);
        settle(6);
        ck("bad_kw", 16'(kw_s == "VC"), 16'h0001);
        ck("bad_data", 16'(pr_s == ""), 16'h0001);
        ck("host_hung", hung, 1'h0);
        // all live bits high: unused read zero, bits 9 and 12 only as events
        @(posedge core_clk);
        kw_bad <= 1'h0;
        {op_cond_in, qu_cond_in} <= 32'hFFFFFFFF;
        settle(3);
        ck("op_cond", operation_condition, OP_COND_MASK);
        ck("qu_cond", questionable_condition, QU_MASK);
        ck("op_event", op_event, OP_EVT_MASK);
        ck("qu_event", qu_event, QU_MASK);
        @(posedge core_clk);
        {op_enable, questionable_enable_reg, sre_in} <= 40'h0002000108;
        settle(3);
        ck("stb_rqs", {srq, status_byte[7:6], status_byte[3]}, 4'hF);
        @(posedge core_clk);
        {qu_event_rd, op_event_rd} <= 2'h3;
        @(posedge core_clk);
        {qu_event_rd, op_event_rd} <= 2'h0;
        settle(3);
        ck("events_read", qu_event | op_event, 16'h0000);
        ck("stb_clear", {srq, status_byte}, 9'h000);
        ck("cond_kept", questionable_condition, QU_MASK);
        @(posedge core_clk);
        {esb_summary, err_queue_nonempty, out_buf_avail, sre_in} <= 11'h710;
        settle(3);
        ck("stb_err_mav", status_byte & 8'h78, 8'h78);
        @(posedge core_clk);
        {err_queue_nonempty, out_buf_avail, ext_ref_en, qu_cond_in} <= 19'h11000;
        settle(3);
        ck("prot_pair", questionable_condition[13:12], 2'h3);
        ck("prot_disp", {voltage_limit_trip_display, current_limit_trip_display}, 2'h3);
        @(posedge core_clk);
        {trig_ext_src, trig_in_pin, op_cond_in} <= 18'h30020;
        settle(8);
        @(posedge core_clk);
        trig_in_pin <= 1'h0;
        settle(8);
        @(posedge core_clk);
        op_cond_in <= 16'h0000;
        settle(8);
        ck("wtg_hold", {waiting_for_trigger_flag, operation_condition[5]}, 2'h3);
        @(posedge core_clk);
        trig_in_pin <= 1'h1;
        settle(8);
        ck("wtg_free", {waiting_for_trigger_flag, operation_condition[5]}, 2'h0);
        test_done();
    end
endmodule : scp_parser_status_tb
bind scp_parser_status scp_parser_status_chk chk (.core_clk, .rst, .qu_cond_in, .ext_ref_en,
    .questionable_enable_reg, .sre_in, .qu_event_rd, .err_queue_nonempty, .out_buf_avail,
    .operation_condition, .questionable_condition, .qu_event, .status_byte, .srq, .msg_end,
    .unit_end, .tok_level);
